// ===== bench/testbench.sv
// Self-checking bench for the pointer control/status block.
// Assumes the one-cycle bus answer and 1-cycle stream latency.
`timescale 1ns/1ps
module testbench;
    logic        ref_clk_i = 0, sys_rst_i = 1, ce_i = 1, rd = 0, wr = 0, wt;
    logic [9:0]  adr = 0;
    logic [31:0] wd = 0, rdat, q;
    logic [41:0] gcfg = {21{2'h3}};
    logic [20:0] lop = 0, tj = 0, pf, fj;
    logic [2:0]  aiv = 0, aii = 0, fe = 0, ipj = 0, inj = 0, opj = 0, onj = 0, hj = 0;
    logic [2:0]  sv = 0, st4 = 0, svo, airq, pirq, pas;
    logic [23:0] sb = 0, sbo;
    logic [5:0]  sk = 0;
    int          mismatches = 0, check_count = 0, cyc = 0;
    always #50 ref_clk_i = ~ref_clk_i;
    tpc_ptr_ctrl_status u_tpc_ptr_ctrl_status (.ref_clk_i, .sys_rst_i, .ce_i, .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(4'hF), .avs_writedata_i(wd),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .group_config_i(gcfg), .lop_state_i(lop),
        .ais_state_i(21'h0), .trib_just_i(tj), .ho_just_i(hj), .ais_ind_valid_i(aiv), .ais_ind_i(aii),
        .fifo_err_i(fe), .in_pos_just_i(ipj), .in_neg_just_i(inj), .out_pos_just_i(opj),
        .out_neg_just_i(onj), .strm_byte_i(sb), .strm_kind_i(sk), .strm_grp_i(9'h0), .strm_tu4_i(st4),
        .strm_valid_i(sv), .strm_byte_o(sbo), .strm_valid_o(svo), .pointer_follower_mode_o(pf),
        .follow_just_o(fj), .idle_code_select_o(), .tu3_mode_o(), .alarm_irq_o(airq),
        .pointer_event_irq_o(pirq), .path_alarm_status_o(pas));
    task automatic wrap_up;
        if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input [31:0] seen, input [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input bit w, input [7:0] idx, input [7:0] d);
        @(posedge ref_clk_i);
        rd <= !w; wr <= w; adr <= {idx, 2'b00}; wd <= {24'h00_0000, d};
        do @(posedge ref_clk_i); while (wt !== 1'b0);
        q = rdat; rd <= 0; wr <= 0;
    endtask
    task automatic rdc(input [7:0] idx, input [31:0] exp);
        bus(0, idx, 8'h00);
        chk("readdata", q, exp);
    endtask
    task automatic sx(input [7:0] cf, input [1:0] k, input ic, input t, input [7:0] b, input [7:0] exp);
        bus(1, 8'hF0, {7'h00, ic}); bus(1, 8'h38, cf);
        @(posedge ref_clk_i); sv[0] <= 1; sk[1:0] <= k; sb[7:0] <= b; st4[0] <= t;
        @(posedge ref_clk_i); sv[0] <= 0;
        @(posedge ref_clk_i);
        chk("stream byte", sbo[7:0], exp);
    endtask
    task automatic ind(input v);
        @(posedge ref_clk_i); aiv[0] <= 1; aii[0] <= v;
        @(posedge ref_clk_i); aiv[0] <= 0;
    endtask
    task automatic ev(input [4:0] e);
        @(posedge ref_clk_i); {fe[0], ipj[0], inj[0], opj[0], onj[0]} <= e;
        @(posedge ref_clk_i); {fe[0], ipj[0], inj[0], opj[0], onj[0]} <= 5'h00;
        repeat (2) @(posedge ref_clk_i);
    endtask
    always @(posedge ref_clk_i) if (++cyc > 3000) begin mismatches++; wrap_up; end
    initial begin
        repeat (20) @(posedge ref_clk_i); sys_rst_i <= 0;
        rdc(8'h38, 32'hC0);
        rdc(8'hA0, 32'h00); rdc(8'h10, 32'h00);
        bus(1, 8'h38, 8'hFF); rdc(8'h38, 32'hEF);
        sx(1, 0, 0, 1, 8'h5A, 8'hFF);
        sx(5, 2, 0, 1, 8'h5A, 8'hFF);
        sx(3, 0, 0, 1, 8'h5A, 8'h00);
        sx(2, 0, 1, 1, 8'h5A, 8'hFF);
        sx(2, 1, 1, 1, 8'h5A, 8'h00);
        sx(2, 3, 1, 1, 8'h5A, 8'h5A);
        sx(6, 2, 0, 1, 8'h5A, 8'hAA);
        sx(1, 0, 0, 0, 8'h5A, 8'h5A);
        gcfg[1:0] <= 2'h2; sx(1, 0, 0, 1, 8'h5A, 8'h5A);
        rdc(8'h38, 32'h81);
        gcfg[3:0] <= 4'hB; bus(1, 8'h38, 8'h00); lop[1:0] <= 2'b11; repeat (3) @(posedge ref_clk_i);
        chk("alarm irq", airq, 0);
        rdc(8'h38, 32'hD0);
        rdc(8'h3F, 32'h01);
        rdc(8'h3F, 32'h00);
        bus(1, 8'h38, 8'h08); lop[0] <= 0; repeat (3) @(posedge ref_clk_i);
        chk("alarm irq", airq, 1);
        rdc(8'h3F, 32'h01);
        bus(1, 8'h38, 8'h20); @(posedge ref_clk_i);
        chk("follower", pf[0], 1);
        for (int i = 0; i < 2; i++) begin
            tj[0] <= !i; hj[0] <= i; @(posedge ref_clk_i); tj[0] <= 0; hj[0] <= 0; @(posedge ref_clk_i);
            chk("follow just", fj[0], 1);
        end
        bus(1, 8'hF0, 8'h04); lop[0] <= 1; repeat (3) @(posedge ref_clk_i); rdc(8'h3F, 32'h00);
        bus(1, 8'hA0, 8'h05); ind(1); rdc(8'hA0, 32'h07);
        chk("path alarm", pas, 1);
        ind(0); bus(1, 8'hA0, 8'h04); ind(1); ind(1); rdc(8'hA0, 32'h04);
        ind(1); rdc(8'hA0, 32'h06);
        bus(1, 8'hF0, 8'h02); ev(5'h19); chk("event irq", pirq, 1);
        rdc(8'hA0, 32'h1E);
        rdc(8'hA0, 32'h06);
        bus(1, 8'hF0, 8'h00); bus(1, 8'hA0, 8'h00); ev(5'h0F); chk("event irq", pirq, 0);
        rdc(8'hA0, 32'h32);
        wrap_up;
    end
endmodule

// ===== bench/tpc_ptr_ctrl_status_properties.sv
// Port checker for the pointer control/status block.
// Assumes ce_i held high and one clock domain.
`timescale 1ns/1ps
module tpc_props #(parameter NUM_PROC = 3, parameter GROUPS = 7) (
    input wire ref_clk_i, sys_rst_i, avs_read_i, avs_write_i, avs_waitrequest_o,
    input wire [31:0] avs_readdata_o,
    input wire [8*NUM_PROC-1:0] strm_byte_i, strm_byte_o,
    input wire [NUM_PROC-1:0] strm_tu4_i, strm_valid_i, strm_valid_o, ho_just_i,
    input wire [NUM_PROC-1:0] ais_ind_valid_i, ais_ind_i, path_alarm_status_o,
    input wire [GROUPS*NUM_PROC-1:0] trib_just_i, follow_just_o);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    wire req = avs_read_i | avs_write_i;
    property p_ans; req && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o; endproperty
    a_ans: assert property (p_ans) else $error("bus answer wrong");
    property p_idle; !req |=> avs_waitrequest_o; endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    property p_hi; !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h00_0000; endproperty
    a_hi: assert property (p_hi) else $error("upper read bits set");
    property p_val; strm_valid_o == $past(strm_valid_i); endproperty
    a_val: assert property (p_val) else $error("stream valid lost");
    property p_non4; strm_valid_i[0] && !strm_tu4_i[0] |=> strm_byte_o[7:0] == $past(strm_byte_i[7:0]); endproperty
    a_non4: assert property (p_non4) else $error("other byte altered");
    property p_fol; follow_just_o[0] |-> $past(trib_just_i[0] | ho_just_i[0]); endproperty
    a_fol: assert property (p_fol) else $error("follow without cause");
    property p_aset; $rose(path_alarm_status_o[0]) |-> $past(ais_ind_valid_i[0] & ais_ind_i[0], 2); endproperty
    a_aset: assert property (p_aset) else $error("alarm set without cause");
    property p_aclr; $fell(path_alarm_status_o[0]) |-> $past(ais_ind_valid_i[0] & ~ais_ind_i[0], 2); endproperty
    a_aclr: assert property (p_aclr) else $error("alarm cleared without cause");
    c_rd: cover property (avs_read_i && !avs_waitrequest_o);
    c_ais: cover property ($rose(path_alarm_status_o[0]));
    c_fol: cover property (follow_just_o[0]);
endmodule
bind tpc_ptr_ctrl_status tpc_props #(.NUM_PROC(NUM_PROC), .GROUPS(GROUPS)) u_tpc_props (.ref_clk_i, .sys_rst_i,
    .avs_read_i, .avs_write_i, .avs_waitrequest_o, .avs_readdata_o, .strm_byte_i, .strm_byte_o, .strm_tu4_i,
    .strm_valid_i, .strm_valid_o, .ho_just_i, .ais_ind_valid_i, .ais_ind_i, .path_alarm_status_o,
    .trib_just_i, .follow_just_o);

// ===== rtl/tpc_byte_proc.v
// Outgoing byte substitution for one tributary byte stream.
// Assumes controls already qualified for the byte's tributary.
`timescale 1ns/1ps
`include "tpc_ptr_regs.vh"

module tpc_byte_proc (
    // Clock and reset
    input  wire       ref_clk_i,
    input  wire       sys_rst_i,
    input  wire       ce_i,
    // Incoming byte
    input  wire [7:0] byte_i,
    input  wire [1:0] kind_i,
    input  wire       valid_i,
    // Controls
    input  wire       ais_i,
    input  wire       idle_i,
    input  wire       diag_i,
    input  wire       ones_i,
    // Outgoing byte
    output reg  [7:0] byte_o,
    output reg        valid_o
);

    reg [7:0] byte_next;
    reg       is_ptr;

    // ------------------------------------------------------------
    // Substitution
    // ------------------------------------------------------------
    always @* begin
        is_ptr    = (kind_i == `TPC_BK_PTR_NDF) || (kind_i == `TPC_BK_PTR_OTHER);
        byte_next = byte_i;
        if (idle_i) begin
            if (kind_i == `TPC_BK_V5) begin
                byte_next = `TPC_BYTE_ZERO;
            end else if (!is_ptr) begin
                byte_next = ones_i ? `TPC_BYTE_ONES : `TPC_BYTE_ZERO;
            end else if (diag_i && kind_i == `TPC_BK_PTR_NDF) begin
                byte_next = byte_i ^ `TPC_NDF_MASK;
            end
        end else if (ais_i) begin
            byte_next = `TPC_BYTE_ONES;
        end else if (diag_i && kind_i == `TPC_BK_PTR_NDF) begin
            byte_next = byte_i ^ `TPC_NDF_MASK;
        end
    end

    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            byte_o  <= `TPC_BYTE_ZERO;
            valid_o <= 1'b0;
        end else if (ce_i) begin
            byte_o  <= byte_next;
            valid_o <= valid_i;
        end
    end

endmodule

// ===== rtl/tpc_ptr_ctrl_status.v
// Fourth-tributary control/status, loss-of-pointer flags and first
// tributary alarm status for three pointer processors.
// Assumes all status inputs come from logic on ref_clk_i.
`timescale 1ns/1ps
`include "tpc_ptr_regs.vh"

// Summary of operation
// - AIS insert drives every outgoing byte of the tributary to all ones.
// - Idle insert wins over AIS insert when both are set.
// - Idle replaces payload with idle code and forces V5 to zero.
// - Pointer bytes pass unchanged during idle insertion, except an NDF pointer byte with pointer diagnose set.
// - Idle code is zeros or ones by idle-code select.
// - Pointer diagnose inverts NDF of outgoing pointer, also with idle.
// - Pointer diagnose is ignored while AIS insert is set and idle insert is clear.
// - Alarm enable gates loss-of-pointer and AIS change interrupts.
// - Live loss-of-pointer status of each fourth tributary is readable.
// - Follower mode collapses FIFO dead zone for the tributary.
// - Follower mode forwards every tributary or higher-order justification.
// - Group configuration bits mirror the first tributary's setting.
// - Fourth-tributary controls act only in four-tributary groups, not TU3.
// - Per-group loss-of-pointer flags set on any change of an active fourth tributary, cleared by read.
// - Flags read zero in TU3 mode or for inactive fourth tributary.
// - Flags latch even while alarm enable is clear.
// - First alarm register reports TU3 in TU3 mode, else first tributary.
// - AIS declared after one indication with relay set, else three.
// - Pointer-event enable gates FIFO error and justification interrupts.
// - Elastic store error flag sets on FIFO slip, clears on read.
// - Justification flags follow monitor select and clear on read.
// - Live path AIS status of first tributary or TU3 is readable.
module tpc_ptr_ctrl_status #(
    parameter NUM_PROC = 3,
    parameter GROUPS   = 7
) (
    // Clock, reset, enable
    input  wire                         ref_clk_i,
    input  wire                         sys_rst_i,
    input  wire                         ce_i,
    // Avalon-MM slave
    input  wire [9:0]                   avs_address_i,
    input  wire                         avs_read_i,
    input  wire                         avs_write_i,
    input  wire [3:0]                   avs_byteenable_i,
    input  wire [31:0]                  avs_writedata_i,
    output reg  [31:0]                  avs_readdata_o,
    output reg                          avs_waitrequest_o,
    // Group configuration and fourth-tributary status
    input  wire [2*GROUPS*NUM_PROC-1:0] group_config_i,
    input  wire [GROUPS*NUM_PROC-1:0]   lop_state_i,
    input  wire [GROUPS*NUM_PROC-1:0]   ais_state_i,
    input  wire [GROUPS*NUM_PROC-1:0]   trib_just_i,
    input  wire [NUM_PROC-1:0]          ho_just_i,
    // First tributary / TU3 events
    input  wire [NUM_PROC-1:0]          ais_ind_valid_i,
    input  wire [NUM_PROC-1:0]          ais_ind_i,
    input  wire [NUM_PROC-1:0]          fifo_err_i,
    input  wire [NUM_PROC-1:0]          in_pos_just_i,
    input  wire [NUM_PROC-1:0]          in_neg_just_i,
    input  wire [NUM_PROC-1:0]          out_pos_just_i,
    input  wire [NUM_PROC-1:0]          out_neg_just_i,
    // Outgoing byte streams
    input  wire [8*NUM_PROC-1:0]        strm_byte_i,
    input  wire [2*NUM_PROC-1:0]        strm_kind_i,
    input  wire [3*NUM_PROC-1:0]        strm_grp_i,
    input  wire [NUM_PROC-1:0]          strm_tu4_i,
    input  wire [NUM_PROC-1:0]          strm_valid_i,
    output wire [8*NUM_PROC-1:0]        strm_byte_o,
    output wire [NUM_PROC-1:0]          strm_valid_o,
    // Pointer generator controls
    output reg  [GROUPS*NUM_PROC-1:0]   pointer_follower_mode_o,
    output reg  [GROUPS*NUM_PROC-1:0]   follow_just_o,
    output reg  [NUM_PROC-1:0]          idle_code_select_o,
    output reg  [NUM_PROC-1:0]          tu3_mode_o,
    // Interrupt requests and live status
    output reg  [NUM_PROC-1:0]          alarm_irq_o,
    output reg  [NUM_PROC-1:0]          pointer_event_irq_o,
    output reg  [NUM_PROC-1:0]          path_alarm_status_o
);

    localparam NT = GROUPS * NUM_PROC;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    reg [5:0]          ctl_reg [0:NT-1];
    reg [NT-1:0]       lop_flag_reg;
    reg [NT-1:0]       lop_flag_next;
    reg [NT-1:0]       lop_prev_reg;
    reg [NT-1:0]       ais_prev_reg;
    reg [NT-1:0]       act;
    reg [NUM_PROC-1:0] evt_en_reg;
    reg [NUM_PROC-1:0] relay_reg;
    reg [NUM_PROC-1:0] ais_st_reg;
    reg [NUM_PROC-1:0] ese_reg;
    reg [NUM_PROC-1:0] pj_reg;
    reg [NUM_PROC-1:0] nj_reg;
    reg [NUM_PROC-1:0] ese_next;
    reg [NUM_PROC-1:0] pj_next;
    reg [NUM_PROC-1:0] nj_next;
    reg [NUM_PROC-1:0] idle_code_reg;
    reg [NUM_PROC-1:0] mon_in_reg;
    reg [NUM_PROC-1:0] tu3_reg;
    reg [1:0]          ais_cnt_reg [0:NUM_PROC-1];
    reg [NUM_PROC-1:0] px_ais;
    reg [NUM_PROC-1:0] px_idle;
    reg [NUM_PROC-1:0] px_diag;
    reg [7:0]          rd_byte;
    reg [2:0]          grp;

    wire [7:0] idx  = avs_address_i[9:2];
    wire       acc  = (avs_read_i || avs_write_i) && avs_waitrequest_o;
    wire       wr   = acc && avs_write_i && avs_byteenable_i[0];
    wire       rd   = acc && avs_read_i;
    wire [2:0] kind = dec_kind(idx);
    wire [1:0] vsel = dec_tributary_pointer_processor(idx);

    // Loop and index variables, one set per process
    integer t;
    integer v;
    integer si;
    integer rt;
    integer ci;
    integer ct;
    integer cv;
    integer cg;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function [2:0] dec_kind;
        input [7:0] a;
        reg   [2:0] pg;
        begin
            pg       = a[7:5];
            dec_kind = `TPC_KIND_NONE;
            if (a[7:4] == `TPC_AUX_PAGE) begin
                if (a[3:0] < NUM_PROC)
                    dec_kind = `TPC_KIND_AUX;
            end else if (pg >= `TPC_CFG_PAGE && pg < `TPC_CFG_PAGE + NUM_PROC) begin
                if (a[4:0] == `TPC_LOP_ROW)
                    dec_kind = `TPC_KIND_LOP;
                else if (a[4:0] >= `TPC_CFG_ROW_FIRST && a[4:0] <= `TPC_CFG_ROW_LAST)
                    dec_kind = `TPC_KIND_CFG;
            end else if (pg >= `TPC_ALM_PAGE && pg < `TPC_ALM_PAGE + NUM_PROC) begin
                if (a[4:0] == `TPC_ALM_ROW)
                    dec_kind = `TPC_KIND_ALM;
            end
        end
    endfunction

    function [1:0] dec_tributary_pointer_processor;
        input [7:0] a;
        begin
            if (a[7:4] == `TPC_AUX_PAGE)
                dec_tributary_pointer_processor = a[1:0];
            else if (a[7])
                dec_tributary_pointer_processor = a[6:5] - 2'h1;
            else
                dec_tributary_pointer_processor = a[6:5] - 2'h1;
        end
    endfunction

    function [1:0] grp_cfg;
        input integer n;
        begin
            grp_cfg = group_config_i[2*n +: 2];
        end
    endfunction

    function [1:0] ais_need;
        input relay;
        begin
            ais_need = relay ? `TPC_AIS_NEED_RELAY : `TPC_AIS_NEED_NORMAL;
        end
    endfunction

    // ------------------------------------------------------------
    // Activity, flag next values, stream controls
    // ------------------------------------------------------------
    always @* begin
        for (t = 0; t < NT; t = t + 1) begin
            act[t] = !tu3_reg[t / GROUPS] && (grp_cfg(t) == `TPC_GRP_ALL_FOUR);
            lop_flag_next[t] = lop_flag_reg[t];
            if (rd && kind == `TPC_KIND_LOP && vsel == t / GROUPS)
                lop_flag_next[t] = 1'b0;
            if (act[t] && (lop_state_i[t] != lop_prev_reg[t]))
                lop_flag_next[t] = 1'b1;
        end
        for (v = 0; v < NUM_PROC; v = v + 1) begin
            ese_next[v] = ese_reg[v];
            pj_next[v]  = pj_reg[v];
            nj_next[v]  = nj_reg[v];
            if (rd && kind == `TPC_KIND_ALM && vsel == v) begin
                ese_next[v] = 1'b0;
                pj_next[v]  = 1'b0;
                nj_next[v]  = 1'b0;
            end
            if (fifo_err_i[v])
                ese_next[v] = 1'b1;
            if (mon_in_reg[v] ? in_pos_just_i[v] : out_pos_just_i[v])
                pj_next[v] = 1'b1;
            if (mon_in_reg[v] ? in_neg_just_i[v] : out_neg_just_i[v])
                nj_next[v] = 1'b1;
            grp = strm_grp_i[3*v +: 3];
            si  = v * GROUPS + grp;
            px_ais[v]  = 1'b0;
            px_idle[v] = 1'b0;
            px_diag[v] = 1'b0;
            if (strm_tu4_i[v] && grp < GROUPS) begin
                if (act[si]) begin
                    px_ais[v]  = ctl_reg[si][`TPC_B_AIS_INS];
                    px_idle[v] = ctl_reg[si][`TPC_B_IDLE_INS];
                    px_diag[v] = ctl_reg[si][`TPC_B_DIAG];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Read data mux
    // ------------------------------------------------------------
    always @* begin
        rd_byte = `TPC_BYTE_ZERO;
        rt      = 0;
        ci      = vsel * GROUPS + (idx[4:0] - `TPC_CFG_ROW_FIRST);
        case (kind)
            `TPC_KIND_CFG: begin
                rd_byte = {grp_cfg(ci), ctl_reg[ci]};
                rd_byte[`TPC_B_LOST] = lop_state_i[ci];
            end
            `TPC_KIND_LOP: begin
                for (rt = 0; rt < GROUPS; rt = rt + 1)
                    rd_byte[rt] = lop_flag_reg[vsel * GROUPS + rt] && act[vsel * GROUPS + rt];
            end
            `TPC_KIND_ALM: begin
                rd_byte[`TPC_B_RELAY]  = relay_reg[vsel];
                rd_byte[`TPC_B_AIS_ST] = ais_st_reg[vsel];
                rd_byte[`TPC_B_EVT_EN] = evt_en_reg[vsel];
                rd_byte[`TPC_B_ESE]    = ese_reg[vsel];
                rd_byte[`TPC_B_PJ]     = pj_reg[vsel];
                rd_byte[`TPC_B_NJ]     = nj_reg[vsel];
            end
            `TPC_KIND_AUX: begin
                rd_byte[`TPC_B_IDLE_CODE] = idle_code_reg[vsel];
                rd_byte[`TPC_B_MON_IN]    = mon_in_reg[vsel];
                rd_byte[`TPC_B_TU3]       = tu3_reg[vsel];
            end
            default: begin
                rd_byte = `TPC_BYTE_ZERO;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers, bus answer and outputs
    // ------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            avs_waitrequest_o       <= 1'b1;
            avs_readdata_o          <= {32{1'b0}};
            lop_flag_reg            <= {NT{1'b0}};
            lop_prev_reg            <= {NT{1'b0}};
            ais_prev_reg            <= {NT{1'b0}};
            pointer_follower_mode_o <= {NT{1'b0}};
            follow_just_o           <= {NT{1'b0}};
            evt_en_reg              <= {NUM_PROC{1'b0}};
            relay_reg               <= {NUM_PROC{1'b0}};
            ais_st_reg              <= {NUM_PROC{1'b0}};
            ese_reg                 <= {NUM_PROC{1'b0}};
            pj_reg                  <= {NUM_PROC{1'b0}};
            nj_reg                  <= {NUM_PROC{1'b0}};
            idle_code_reg           <= {NUM_PROC{1'b0}};
            mon_in_reg              <= {NUM_PROC{1'b0}};
            tu3_reg                 <= {NUM_PROC{1'b0}};
            idle_code_select_o      <= {NUM_PROC{1'b0}};
            tu3_mode_o              <= {NUM_PROC{1'b0}};
            alarm_irq_o             <= {NUM_PROC{1'b0}};
            pointer_event_irq_o     <= {NUM_PROC{1'b0}};
            path_alarm_status_o     <= {NUM_PROC{1'b0}};
            for (ct = 0; ct < NT; ct = ct + 1)
                ctl_reg[ct] <= `TPC_CTL_RESET;
            for (cv = 0; cv < NUM_PROC; cv = cv + 1)
                ais_cnt_reg[cv] <= 2'h0;
        end else if (ce_i) begin
            if (acc) begin
                avs_waitrequest_o <= 1'b0;
                avs_readdata_o    <= {{24{1'b0}}, rd_byte};
            end else begin
                avs_waitrequest_o <= 1'b1;
            end
            lop_flag_reg <= lop_flag_next;
            lop_prev_reg <= lop_state_i;
            ais_prev_reg <= ais_state_i;
            ese_reg      <= ese_next;
            pj_reg       <= pj_next;
            nj_reg       <= nj_next;
            for (ct = 0; ct < NT; ct = ct + 1) begin
                if (wr && kind == `TPC_KIND_CFG && ci == ct) begin
                    ctl_reg[ct][`TPC_B_AIS_INS]  <= avs_writedata_i[`TPC_B_AIS_INS];
                    ctl_reg[ct][`TPC_B_IDLE_INS] <= avs_writedata_i[`TPC_B_IDLE_INS];
                    ctl_reg[ct][`TPC_B_DIAG]     <= avs_writedata_i[`TPC_B_DIAG];
                    ctl_reg[ct][`TPC_B_ALM_EN]   <= avs_writedata_i[`TPC_B_ALM_EN];
                    ctl_reg[ct][`TPC_B_FOLLOW]   <= avs_writedata_i[`TPC_B_FOLLOW];
                end
                pointer_follower_mode_o[ct] <= act[ct] && ctl_reg[ct][`TPC_B_FOLLOW];
                follow_just_o[ct] <= act[ct] && ctl_reg[ct][`TPC_B_FOLLOW]
                                     && (trib_just_i[ct] || ho_just_i[ct / GROUPS]);
            end
            for (cv = 0; cv < NUM_PROC; cv = cv + 1) begin
                if (wr && kind == `TPC_KIND_ALM && vsel == cv) begin
                    evt_en_reg[cv] <= avs_writedata_i[`TPC_B_EVT_EN];
                    relay_reg[cv]  <= avs_writedata_i[`TPC_B_RELAY];
                end
                if (wr && kind == `TPC_KIND_AUX && vsel == cv) begin
                    idle_code_reg[cv] <= avs_writedata_i[`TPC_B_IDLE_CODE];
                    mon_in_reg[cv]    <= avs_writedata_i[`TPC_B_MON_IN];
                    tu3_reg[cv]       <= avs_writedata_i[`TPC_B_TU3];
                end
                // Count widened so a saturated count cannot wrap
                if (ais_ind_valid_i[cv]) begin
                    if (!ais_ind_i[cv]) begin
                        ais_cnt_reg[cv] <= 2'h0;
                        ais_st_reg[cv]  <= 1'b0;
                    end else if ({1'b0, ais_cnt_reg[cv]} + 3'h1 >= {1'b0, ais_need(relay_reg[cv])}) begin
                        ais_cnt_reg[cv] <= ais_need(relay_reg[cv]);
                        ais_st_reg[cv]  <= 1'b1;
                    end else begin
                        ais_cnt_reg[cv] <= ais_cnt_reg[cv] + 2'h1;
                    end
                end
                path_alarm_status_o[cv] <= ais_st_reg[cv];
                idle_code_select_o[cv]  <= idle_code_reg[cv];
                tu3_mode_o[cv]          <= tu3_reg[cv];
                pointer_event_irq_o[cv] <= evt_en_reg[cv] && (ese_reg[cv] || pj_reg[cv] || nj_reg[cv]);
                alarm_irq_o[cv] <= 1'b0;
                for (cg = 0; cg < GROUPS; cg = cg + 1) begin
                    if (act[cv * GROUPS + cg] && ctl_reg[cv * GROUPS + cg][`TPC_B_ALM_EN]
                        && (lop_flag_reg[cv * GROUPS + cg]
                            || ais_state_i[cv * GROUPS + cg] != ais_prev_reg[cv * GROUPS + cg]))
                        alarm_irq_o[cv] <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Byte substitution per processor
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_PROC; g = g + 1) begin : gen_proc
            tpc_byte_proc u_proc (
                .ref_clk_i (ref_clk_i),
                .sys_rst_i (sys_rst_i),
                .ce_i      (ce_i),
                .byte_i    (strm_byte_i[8*g +: 8]),
                .kind_i    (strm_kind_i[2*g +: 2]),
                .valid_i   (strm_valid_i[g]),
                .ais_i     (px_ais[g]),
                .idle_i    (px_idle[g]),
                .diag_i    (px_diag[g]),
                .ones_i    (idle_code_reg[g]),
                .byte_o    (strm_byte_o[8*g +: 8]),
                .valid_o   (strm_valid_o[g])
            );
        end
    endgenerate

endmodule

// ===== rtl/tpc_ptr_regs.vh
// Register map, field positions, reset values and codes for the
// tributary pointer control and status block.
// Assumes inclusion by bare name from the design files.
`ifndef TPC_PTR_REGS_VH
`define TPC_PTR_REGS_VH

// ----------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define TPC_IDX_CFG_A        8'h38
`define TPC_IDX_LOP_A        8'h3F
`define TPC_IDX_CFG_B        8'h58
`define TPC_IDX_LOP_B        8'h5F
`define TPC_IDX_CFG_C        8'h78
`define TPC_IDX_LOP_C        8'h7F
`define TPC_IDX_ALM_A        8'hA0
`define TPC_IDX_ALM_B        8'hC0
`define TPC_IDX_ALM_C        8'hE0
`define TPC_IDX_AUX_BASE     8'hF0
`define TPC_CFG_PAGE         3'h1
`define TPC_ALM_PAGE         3'h5
`define TPC_CFG_ROW_FIRST    5'h18
`define TPC_CFG_ROW_LAST     5'h1E
`define TPC_LOP_ROW          5'h1F
`define TPC_ALM_ROW          5'h00
`define TPC_AUX_PAGE         4'hF

// ----------------------------------------------------------------
// Decoded access kinds
// ----------------------------------------------------------------
`define TPC_KIND_NONE        3'h0
`define TPC_KIND_CFG         3'h1
`define TPC_KIND_LOP         3'h2
`define TPC_KIND_ALM         3'h3
`define TPC_KIND_AUX         3'h4

// ----------------------------------------------------------------
// Configuration/status fields
// ----------------------------------------------------------------
`define TPC_B_AIS_INS        0
`define TPC_B_IDLE_INS       1
`define TPC_B_DIAG           2
`define TPC_B_ALM_EN         3
`define TPC_B_LOST           4
`define TPC_B_FOLLOW         5
`define TPC_CTL_RESET        6'h00
`define TPC_GRP_ALL_FOUR     2'h3

// ----------------------------------------------------------------
// Alarm status fields
// ----------------------------------------------------------------
`define TPC_B_RELAY          0
`define TPC_B_AIS_ST         1
`define TPC_B_EVT_EN         2
`define TPC_B_ESE            3
`define TPC_B_PJ             4
`define TPC_B_NJ             5
`define TPC_AIS_NEED_RELAY   2'h1
`define TPC_AIS_NEED_NORMAL  2'h3

// ----------------------------------------------------------------
// Auxiliary control fields
// ----------------------------------------------------------------
`define TPC_B_IDLE_CODE      0
`define TPC_B_MON_IN         1
`define TPC_B_TU3            2

// ----------------------------------------------------------------
// Byte stream codes
// ----------------------------------------------------------------
`define TPC_BK_PAYLOAD       2'h0
`define TPC_BK_V5            2'h1
`define TPC_BK_PTR_NDF       2'h2
`define TPC_BK_PTR_OTHER     2'h3
`define TPC_BYTE_ONES        8'hFF
`define TPC_BYTE_ZERO        8'h00
`define TPC_NDF_MASK         8'hF0

`endif
